//--- hw/fdpc_pkg.sv
package fdpc_pkg;

    // register byte offsets
    localparam logic [5:0] OFF_DOUT   = 6'h00;
    localparam logic [5:0] OFF_DSR    = 6'h04;
    localparam logic [5:0] OFF_CFG    = 6'h08;
    localparam logic [5:0] OFF_FCT    = 6'h0c;
    localparam logic [5:0] OFF_FEN    = 6'h10;
    localparam logic [5:0] OFF_PMG    = 6'h14;
    localparam logic [5:0] OFF_PAL    = 6'h18;
    localparam logic [5:0] OFF_MODE   = 6'h1c;
    localparam logic [5:0] OFF_SETUP  = 6'h20;
    localparam logic [5:0] OFF_HOLD   = 6'h24;
    localparam logic [5:0] OFF_TIMING = 6'h28;
    localparam logic [5:0] OFF_PORT   = 6'h2c;
    localparam logic [5:0] OFF_PDATA  = 6'h30;
    localparam logic [5:0] OFF_STATUS = 6'h34;
    localparam int         NUM_REGS   = 13;

    // writable reset values
    localparam logic [7:0] RST_DOUT   = 8'h00;
    localparam logic [7:0] RST_DSR    = 8'h02;
    localparam logic [7:0] RST_CFG    = 8'h02;
    localparam logic [7:0] RST_MODE   = 8'h00;
    localparam logic [7:0] RST_SETUP  = 8'h00;
    localparam logic [7:0] RST_HOLD   = 8'h00;
    localparam logic [7:0] RST_OTHER  = 8'h00;

    // field positions
    localparam int DOUT_SEL_LO  = 0;
    localparam int DOUT_MTR_LO  = 4;
    localparam int DSR_RATE_LO  = 0;
    localparam int DSR_PWRDN    = 6;
    localparam int FCT_RATE_OUT = 0;
    localparam int FCT_SEL_PIN  = 2;
    localparam int FCT_SWAP     = 4;
    localparam int FEN_PWRDN    = 3;
    localparam int FEN_FOUR     = 4;
    localparam int PMG_PDN_PIN  = 4;
    localparam int PAL_PWRDN    = 0;
    localparam int MODE_PWRDN   = 0;
    localparam int PORT_SHARED  = 0;
    localparam int PORT_PDIR    = 1;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // registered pin outputs of the block
    typedef struct packed {
        logic       motor_on0_n;
        logic       motor_on1_n;
        logic       shp_motor_n;
        logic       power_down_pin;
        logic       idle_out;
        logic [1:0] ms_o;
        logic [1:0] ms_oe;
        logic [1:0] ms_pullup_en;
        logic [7:0] pdata_o;
        logic [7:0] pdata_oe;
        logic       read_data_n;
    } fdpc_pins_type;

    localparam fdpc_pins_type PINS_IDLE = '{
        motor_on0_n: 1'b1, motor_on1_n: 1'b1, shp_motor_n: 1'b1,
        power_down_pin: 1'b0, idle_out: 1'b1, ms_o: 2'b11, ms_oe: 2'b00,
        ms_pullup_en: 2'b11, pdata_o: 8'h00, pdata_oe: 8'h00,
        read_data_n: 1'b1};

endpackage : fdpc_pkg

//--- hw/fdpc_motor_enc.sv
`timescale 1ns/100ps
`default_nettype none

module fdpc_motor_enc (
    // motor bits and drive select
    input  wire logic [3:0] motor_en,
    input  wire logic [1:0] drive_sel,
    // mode controls
    input  wire logic       four_drive,
    input  wire logic       swap,
    // the two active-low motor pins
    output logic [1:0]      motor_n
);
    import fdpc_pkg::*;

    logic [1:0] pair_n;

    // four-drive: selected drive code if its motor runs, else 11
    always_comb begin
        if (four_drive) begin
            pair_n = motor_en[drive_sel] ? drive_sel : 2'b11;
        end else begin
            pair_n = ~motor_en[1:0];
        end
        // swap sits after encoding so both modes see it alike
        motor_n = swap ? {pair_n[0], pair_n[1]} : pair_n;
    end

endmodule : fdpc_motor_enc
`default_nettype wire

//--- hw/fdpc_top.sv
// Overview of operation
// - master reset forces controller idle and all disk outputs inactive
// - master reset restores output, rate, config, mode, setup, hold registers
// - master reset leaves drive timing parameters alone
// - function control bit 0 clear: media sense pins are inputs, pull-ups on
// - function control bit 0 set: media sense pins drive data rate, pull-ups off
// - motor pins follow the motor bits in upper nibble of output register
// - function enable bit 4 encodes motor pins for four drives
// - function control bit 4 swaps the two motor pin values
// - shared port motor pin selects drive 1, or drive 0 when bit 4 set
// - power-down pin shows power-down, or drive 1 select per management bit 4
// - power-down high when any of four power-down sources is set
// - function control bit 2 set makes shared pin the printer/floppy select
// - outside holds select high for printer, low for floppy; port follows
// - function control bit 2 clear makes shared pin the second drive detect
// - shared port in floppy use gives extra read data and motor
// - disk read data pin feeds the raw bit stream to the controller
// - parallel data pins are bidirectional to the parallel data register
// - idle output high when controller idle or powered down
`timescale 1ns/100ps
`default_nettype none

module fdpc_top #(
    parameter int ADDR_W = 6
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write address and data
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // controller side, same clock
    input  wire logic              fdc_busy,
    output logic                   fdc_reset,
    output logic                   fdc_read_data_n,
    // asynchronous pins in
    input  wire logic              master_reset_in,
    input  wire logic              disk_read_data_n,
    input  wire logic              shp_read_data_n,
    input  wire logic              host_read_n,
    input  wire logic              shared_sel_pin,
    input  wire logic              paper_out,
    input  wire logic [1:0]        ms_i,
    input  wire logic [7:0]        pdata_i,
    // pins out
    output logic                   motor_on0_n,
    output logic                   motor_on1_n,
    output logic                   shp_motor_n,
    output logic                   power_down_pin,
    output logic                   idle_out,
    output logic [1:0]             ms_o,
    output logic [1:0]             ms_oe,
    output logic [1:0]             ms_pullup_en,
    output logic [7:0]             pdata_o,
    output logic [7:0]             pdata_oe
);
    import fdpc_pkg::*;

    initial begin
        if (ADDR_W < 6) begin
            $error("fdpc_top: ADDR_W must be at least 6");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage feeds only the second

    localparam int NSYNC = 16;
    localparam logic [NSYNC-1:0] SYNC_IDLE = 16'h00ce; // pins at rest, no false edge
    logic [NSYNC-1:0] sync1_q, sync2_q, sync_in;

    assign sync_in = {pdata_i, ms_i, paper_out, shared_sel_pin, host_read_n,
                      shp_read_data_n, disk_read_data_n, master_reset_in};

    // two flops per pin before any logic looks at it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= SYNC_IDLE;
            sync2_q <= SYNC_IDLE;
        end else begin
            sync1_q <= sync_in;
            sync2_q <= sync1_q;
        end
    end

    logic       mrst, rdata_n, shp_rdata_n, host_rd_n, sel_pin, pout;
    logic [1:0] ms_s;
    logic [7:0] pdata_s;

    assign mrst        = sync2_q[0];
    assign rdata_n     = sync2_q[1];
    assign shp_rdata_n = sync2_q[2];
    assign host_rd_n   = sync2_q[3];
    assign sel_pin     = sync2_q[4];
    assign pout        = sync2_q[5];
    assign ms_s        = sync2_q[7:6];
    assign pdata_s     = sync2_q[15:8];

    ////////////////////////////////////////////////////////////////////////
    // register file

    logic [7:0] regs_q [NUM_REGS];
    logic [7:0] regs_d [NUM_REGS];

    // byte offset to register slot; -1 for unmapped or read-only
    function automatic int reg_slot(input logic [ADDR_W-1:0] a);
        if ((a >> 6) != '0 || a[1:0] != 2'b00) begin
            return -1;
        end
        case (a[5:0])
            OFF_DOUT, OFF_DSR, OFF_CFG, OFF_FCT, OFF_FEN, OFF_PMG, OFF_PAL,
            OFF_MODE, OFF_SETUP, OFF_HOLD, OFF_TIMING, OFF_PORT,
            OFF_PDATA: return int'(a[5:2]);
            default:   return -1;
        endcase
    endfunction : reg_slot

    localparam int S_DOUT = int'(OFF_DOUT[5:2]);
    localparam int S_DSR  = int'(OFF_DSR[5:2]);
    localparam int S_CFG  = int'(OFF_CFG[5:2]);
    localparam int S_FCT  = int'(OFF_FCT[5:2]);
    localparam int S_FEN  = int'(OFF_FEN[5:2]);
    localparam int S_PMG  = int'(OFF_PMG[5:2]);
    localparam int S_PAL  = int'(OFF_PAL[5:2]);
    localparam int S_MODE = int'(OFF_MODE[5:2]);
    localparam int S_SET  = int'(OFF_SETUP[5:2]);
    localparam int S_HOLD = int'(OFF_HOLD[5:2]);
    localparam int S_PORT = int'(OFF_PORT[5:2]);
    localparam int S_PDAT = int'(OFF_PDATA[5:2]);

    ////////////////////////////////////////////////////////////////////////
    // axi write: address and data in either order

    logic              aw_held_q, aw_held_d, w_held_q, w_held_d;
    logic              bvalid_q, bvalid_d;
    logic [1:0]        bresp_q, bresp_d;
    logic [ADDR_W-1:0] waddr_q, waddr_d;
    logic [7:0]        wbyte_q, wbyte_d;
    logic              wlane_q, wlane_d;
    logic              do_write;
    int                wslot;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign do_write      = aw_held_q && w_held_q && !bvalid_q;
    assign wslot         = reg_slot(waddr_q);

    // capture halves, answer once both are in
    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        waddr_d   = waddr_q;
        wbyte_d   = wbyte_q;
        wlane_d   = wlane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_d = 1'b1;
            waddr_d   = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_d = 1'b1;
            wbyte_d  = s_axi_wdata[7:0];
            wlane_d  = s_axi_wstrb[0];
        end
        if (do_write) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = (wslot < 0) ? RESP_SLVERR : RESP_OKAY;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            waddr_q   <= '0;
            wbyte_q   <= 8'h00;
            wlane_q   <= 1'b0;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            waddr_q   <= waddr_d;
            wbyte_q   <= wbyte_d;
            wlane_q   <= wlane_d;
        end
    end

    // register update; master reset beats a write
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            regs_d[i] = regs_q[i];
        end
        if (do_write && wslot >= 0 && wlane_q) begin
            regs_d[wslot] = wbyte_q;
        end
        if (mrst) begin
            regs_d[S_DOUT] = RST_DOUT;
            regs_d[S_DSR]  = RST_DSR;
            regs_d[S_CFG]  = RST_CFG;
            regs_d[S_MODE] = RST_MODE;
            regs_d[S_SET]  = RST_SETUP;
            regs_d[S_HOLD] = RST_HOLD;
            // drive timing slot deliberately not touched
        end
    end

    // bus reset clears all but rate and config, timing included
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= RST_OTHER;
            end
            regs_q[S_DSR] <= RST_DSR;
            regs_q[S_CFG] <= RST_CFG;
        end else begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= regs_d[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decoded controls

    logic       shp, sel_mode, printer, floppy_port, pwr_down, fdc_idle;
    logic       second_drive, drive1_sel_n;
    logic [1:0] dsel;
    logic [3:0] mtr;
    logic [1:0] motor_pair_n;
    logic [7:0] status;

    assign dsel      = regs_q[S_DOUT][DOUT_SEL_LO +: 2];
    assign mtr       = regs_q[S_DOUT][DOUT_MTR_LO +: 4];
    assign shp       = regs_q[S_PORT][PORT_SHARED];
    assign sel_mode  = regs_q[S_FCT][FCT_SEL_PIN];
    // shared pin is printer select or second drive detect, never both
    assign printer      = sel_mode && sel_pin;
    assign second_drive = !sel_mode && sel_pin;
    assign floppy_port  = shp && sel_mode && !sel_pin;
    // any one source is enough to power the controller down
    assign pwr_down = regs_q[S_DSR][DSR_PWRDN] | regs_q[S_FEN][FEN_PWRDN]
                    | regs_q[S_PAL][PAL_PWRDN] | regs_q[S_MODE][MODE_PWRDN];
    assign fdc_idle     = mrst || !fdc_busy;
    assign fdc_reset    = mrst;
    assign drive1_sel_n = !(dsel == 2'd1);

    fdpc_motor_enc u_motor (
        .motor_en   (mtr),
        .drive_sel  (dsel),
        .four_drive (regs_q[S_FEN][FEN_FOUR]),
        .swap       (regs_q[S_FCT][FCT_SWAP]),
        .motor_n    (motor_pair_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // pin functions from config bits, registered

    fdpc_pins_type pins_q, pins_d;

    // no command stage: bits select the pin use directly
    always_comb begin
        pins_d             = PINS_IDLE;
        pins_d.motor_on0_n = motor_pair_n[0];
        pins_d.motor_on1_n = motor_pair_n[1];
        if (floppy_port) begin
            pins_d.shp_motor_n = regs_q[S_FCT][FCT_SWAP] ?
                                 !mtr[0] : !mtr[1];
        end
        pins_d.power_down_pin = regs_q[S_PMG][PMG_PDN_PIN] ?
                                pwr_down : drive1_sel_n;
        pins_d.idle_out = fdc_idle || pwr_down;
        if (regs_q[S_FCT][FCT_RATE_OUT]) begin
            pins_d.ms_o         = regs_q[S_DSR][DSR_RATE_LO +: 2];
            pins_d.ms_oe        = 2'b11;
            pins_d.ms_pullup_en = 2'b00;
        end else begin
            pins_d.ms_oe        = 2'b00;
            pins_d.ms_pullup_en = 2'b11;
        end
        // printer on the shared port: data pins follow direction bit
        if (shp && printer && !regs_q[S_PORT][PORT_PDIR]) begin
            pins_d.pdata_o  = regs_q[S_PDAT];
            pins_d.pdata_oe = 8'hff;
        end
        // disk read low, or shared port read low in floppy use, reaches the controller
        pins_d.read_data_n = rdata_n && (!floppy_port || shp_rdata_n);
        if (mrst) begin
            // disk outputs inactive in master reset
            pins_d.motor_on0_n    = 1'b1;
            pins_d.motor_on1_n    = 1'b1;
            pins_d.shp_motor_n    = 1'b1;
            pins_d.ms_oe          = 2'b00;
            pins_d.read_data_n    = 1'b1;
            pins_d.power_down_pin = regs_q[S_PMG][PMG_PDN_PIN] ?
                                    pwr_down : 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_q <= PINS_IDLE;
        end else begin
            pins_q <= pins_d;
        end
    end

    assign motor_on0_n     = pins_q.motor_on0_n;
    assign motor_on1_n     = pins_q.motor_on1_n;
    assign shp_motor_n     = pins_q.shp_motor_n;
    assign power_down_pin  = pins_q.power_down_pin;
    assign idle_out        = pins_q.idle_out;
    assign ms_o            = pins_q.ms_o;
    assign ms_oe           = pins_q.ms_oe;
    assign ms_pullup_en    = pins_q.ms_pullup_en;
    assign pdata_o         = pins_q.pdata_o;
    assign pdata_oe        = pins_q.pdata_oe;
    assign fdc_read_data_n = pins_q.read_data_n;

    ////////////////////////////////////////////////////////////////////////
    // axi read channel: one cycle after address

    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;
    int          rslot;

    // sense bits valid only while inputs
    assign status = {pwr_down, fdc_idle, pout, printer, second_drive,
                     host_rd_n, ms_s};
    assign rslot  = reg_slot(s_axi_araddr);

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            if (s_axi_araddr == ADDR_W'(OFF_STATUS)) begin
                rdata_d = {24'h000000, status};
            end else if (s_axi_araddr == ADDR_W'(OFF_PDATA) && !pdata_oe[0]) begin
                rdata_d = {24'h000000, pdata_s};
            end else if (rslot >= 0) begin
                rdata_d = {24'h000000, regs_q[rslot]};
            end else begin
                rdata_d = 32'h00000000;
                rresp_d = RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

endmodule : fdpc_top
`default_nettype wire

//--- tb/fdpc_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module fdpc_monitor (
    // clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // watched inputs
    input wire logic       master_reset_in,
    input wire logic       fdc_busy,
    input wire logic       disk_read_data_n,
    // watched outputs
    input wire logic       motor_on0_n,
    input wire logic       motor_on1_n,
    input wire logic       shp_motor_n,
    input wire logic       idle_out,
    input wire logic       fdc_read_data_n,
    input wire logic [1:0] ms_oe,
    input wire logic [1:0] ms_pullup_en,
    input wire logic [7:0] pdata_oe
);
    // five samples: two sync flops plus output flop
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_mr_motors_off: assert property (master_reset_in [*5] |-> motor_on0_n && motor_on1_n && shp_motor_n)
        else $error("motor on in reset");
    a_mr_read_idle: assert property (master_reset_in [*5] |-> fdc_read_data_n)
        else $error("read active in reset");
    a_mr_sense_off: assert property (master_reset_in [*5] |-> ms_oe == 2'b00)
        else $error("sense driven in reset");
    a_sense_no_fight: assert property ((ms_oe & ms_pullup_en) == 2'b00)
        else $error("sense pin driven with pull-up on");
    a_sense_pair: assert property (ms_oe == 2'b00 || ms_oe == 2'b11)
        else $error("sense pins split");
    a_idle_when_free: assert property (!fdc_busy |=> idle_out)
        else $error("idle low while controller free");
    a_pdata_whole: assert property (pdata_oe == 8'h00 || pdata_oe == 8'hff)
        else $error("parallel data enables split");
    a_port_one_use: assert property (!shp_motor_n |-> pdata_oe == 8'h00)
        else $error("port used twice");
    a_read_stream: assert property ((!disk_read_data_n && !master_reset_in) [*5] |-> !fdc_read_data_n)
        else $error("read stream not passed on");
    // main scenarios reached
    c_floppy_port: cover property (!shp_motor_n);
    c_printer_port: cover property (pdata_oe == 8'hff);
    c_rate_out: cover property (ms_oe == 2'b11);
endmodule : fdpc_monitor
bind fdpc_top fdpc_monitor fdpc_monitor_inst (.aclk(aclk), .aresetn(aresetn),
    .master_reset_in(master_reset_in), .fdc_busy(fdc_busy), .disk_read_data_n(disk_read_data_n),
    .motor_on0_n(motor_on0_n), .motor_on1_n(motor_on1_n), .shp_motor_n(shp_motor_n),
    .idle_out(idle_out), .fdc_read_data_n(fdc_read_data_n), .ms_oe(ms_oe),
    .ms_pullup_en(ms_pullup_en), .pdata_oe(pdata_oe));
`default_nettype wire

//--- tb/fdpc_drive_model.sv
`timescale 1ns/100ps
`default_nettype none
module fdpc_drive_model (
    // clock and bench commands
    input wire logic       aclk,
    input wire logic       printer_on,
    input wire logic       paper_empty,
    input wire logic       rd_on,
    input wire logic [1:0] media_n,
    // pins from the block
    input wire logic [1:0] ms_o,
    input wire logic [1:0] ms_oe,
    input wire logic [1:0] ms_pullup_en,
    input wire logic [7:0] pdata_o,
    input wire logic [7:0] pdata_oe,
    // pins to the block
    output logic           shared_sel_pin,
    output logic           paper_out,
    output logic           disk_read_data_n,
    output logic [1:0]     ms_i,
    output logic [7:0]     pdata_i
);
    logic [7:0] tog_q = 8'h5a;
    // floating lines toggle
    always_ff @(posedge aclk) tog_q <= tog_q + 8'h01;
    assign shared_sel_pin   = printer_on;
    assign paper_out        = printer_on & paper_empty;
    assign disk_read_data_n = ~(rd_on & tog_q[3]);
    assign ms_i    = ms_oe & ms_o | ~ms_oe & (ms_pullup_en & media_n | ~ms_pullup_en & tog_q[1:0]);
    assign pdata_i = pdata_oe & pdata_o | ~pdata_oe & tog_q;
endmodule : fdpc_drive_model
`default_nettype wire

//--- tb/floppy_port_pin_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module floppy_port_pin_control_tb_top;
    import fdpc_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [5:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, v;
    logic [1:0] bresp, rresp, rs, ms_i, ms_o, ms_oe, ms_pu, media_n = 2'b11;
    logic mrst = 0, busy = 1, rd_n = 1, prn = 0, pend = 0, rd_on = 0, awready, wready, bvalid;
    logic arready, rvalid, sel, paper, drd_n, m0_n, m1_n, pm_n, pdn_pin, idle, frd_n;
    logic [7:0] pdi, pdo, pdoe;
    logic [5:0] pa [4] = '{OFF_DSR, OFF_FEN, OFF_PAL, OFF_MODE};
    logic [7:0] pb [4] = '{8'h40, 8'h08, 8'h01, 8'h01};
    int n_mismatch = 0, total_checks = 0;
    always #20 aclk = ~aclk;
    fdpc_top fdpc_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .fdc_busy(busy), .fdc_reset(), .fdc_read_data_n(frd_n),
        .master_reset_in(mrst), .disk_read_data_n(drd_n), .shp_read_data_n(drd_n),
        .host_read_n(rd_n), .shared_sel_pin(sel), .paper_out(paper), .ms_i(ms_i), .pdata_i(pdi),
        .motor_on0_n(m0_n), .motor_on1_n(m1_n), .shp_motor_n(pm_n), .power_down_pin(pdn_pin),
        .idle_out(idle), .ms_o(ms_o), .ms_oe(ms_oe), .ms_pullup_en(ms_pu), .pdata_o(pdo),
        .pdata_oe(pdoe));
    fdpc_drive_model fdpc_drive_model_inst (.aclk(aclk), .printer_on(prn), .paper_empty(pend),
        .rd_on(rd_on), .media_n(media_n), .ms_o(ms_o), .ms_oe(ms_oe), .ms_pullup_en(ms_pu),
        .pdata_o(pdo), .pdata_oe(pdoe), .shared_sel_pin(sel), .paper_out(paper),
        .disk_read_data_n(drd_n), .ms_i(ms_i), .pdata_i(pdi));
    ////////////////////////////////////////////////////////////////////////////////
    // compare and count
    task chk(input logic [31:0] s, input logic [31:0] e, input string n);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : chk
    // aw and w offered together, each dropped when taken
    task wr(input logic [5:0] a, input logic [7:0] d);
        logic ta, tw;
        ta = 0;
        tw = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (!ta && awready) begin ta = 1; awvalid <= 0; end
            if (!tw && wready) begin tw = 1; wvalid <= 0; end
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 0;
        rs = bresp;
    endtask : wr
    task rd(input logic [5:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        rready <= 0; v = rdata; rs = rresp;
    endtask : rd
    task w(input int n); repeat (n) @(posedge aclk); endtask : w
    task mot(input logic [7:0] fe, input logic [7:0] fc, input logic [7:0] d, input logic [1:0] e);
        wr(OFF_FEN, fe); wr(OFF_FCT, fc); wr(OFF_DOUT, d); w(3);
        chk({m1_n, m0_n}, e, "motor pins");
    endtask : mot
    ////////////////////////////////////////////////////////////////////////////////
    task t_regs;
        rd(OFF_DSR); chk(v, RST_DSR, "rate reg");
        rd(OFF_CFG); chk(v, RST_CFG, "config reg");
        rd(6'h38); chk(rs, RESP_SLVERR, "unmapped resp");
    endtask : t_regs
    task t_mr;
        wr(OFF_DOUT, 8'h30); wr(OFF_TIMING, 8'h55); wr(OFF_DSR, 8'h01);
        mrst <= 1; w(5); chk({m1_n, m0_n, frd_n}, 3'b111, "reset pins");
        mrst <= 0; w(4);
        rd(OFF_DOUT); chk(v, RST_DOUT, "output reg");
        rd(OFF_DSR); chk(v, RST_DSR, "rate reg");
        rd(OFF_TIMING); chk(v, 32'h55, "timing reg");
    endtask : t_mr
    task t_motor;
        mot(8'h00, 8'h00, 8'h10, 2'b10);
        mot(8'h00, 8'h00, 8'h20, 2'b01);
        mot(8'h00, 8'h10, 8'h10, 2'b01);
        mot(8'h10, 8'h00, 8'h21, 2'b01);
        mot(8'h10, 8'h10, 8'h21, 2'b10);
        mot(8'h00, 8'h00, 8'h00, 2'b11);
    endtask : t_motor
    task t_sense;
        wr(OFF_DSR, 8'h01); wr(OFF_FCT, 8'h01); w(3);
        chk({ms_oe, ms_pu, ms_o}, 6'b110001, "rate out");
        wr(OFF_FCT, 8'h00); media_n <= 2'b10; w(5);
        chk({ms_oe, ms_pu}, 4'b0011, "sense in");
        rd(OFF_STATUS); chk(v[1:0], 2'b10, "sense status");
    endtask : t_sense
    task t_pd;
        busy <= 0; w(3); chk(idle, 1'b1, "idle free");
        busy <= 1; wr(OFF_PMG, 8'h10);
        for (int i = 0; i < 4; i++) begin
            wr(pa[i], pb[i]); w(3); chk({pdn_pin, idle}, 2'b11, "power down");
            wr(pa[i], 8'h00); w(3); chk({pdn_pin, idle}, 2'b00, "power up");
        end
        wr(OFF_PMG, 8'h00); wr(OFF_DOUT, 8'h01); w(3); chk(pdn_pin, 1'b0, "drive1 sel");
        wr(OFF_DOUT, 8'h00); w(3); chk(pdn_pin, 1'b1, "drive1 off");
    endtask : t_pd
    task t_port;
        rd_on <= 1; wr(OFF_PORT, 8'h01); wr(OFF_FCT, 8'h04); wr(OFF_DOUT, 8'h20); w(5);
        chk(pm_n, 1'b0, "port motor d1");
        wr(OFF_FCT, 8'h14); w(3); chk(pm_n, 1'b1, "port motor swap");
        wr(OFF_DOUT, 8'h10); w(3); chk(pm_n, 1'b0, "port motor d0");
        rd_on <= 0; prn <= 1; pend <= 1; rd_n <= 0; wr(OFF_PDATA, 8'ha5); w(5);
        chk({pm_n, pdoe, pdo}, 17'h1ffa5, "printer port");
        rd(OFF_STATUS); chk({v[5:4], v[2]}, 3'b110, "printer status");
        wr(OFF_FCT, 8'h00); w(3);
        rd(OFF_STATUS); chk({v[4:3], pdoe}, 10'h100, "drive detect use");
    endtask : t_port
    ////////////////////////////////////////////////////////////////////////////////
    task test_done;
        $display("mismatches %0d checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    // watchdog, about thirty times the run
    initial begin
        #400000;
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        t_regs(); t_mr(); t_motor(); t_sense(); t_pd(); t_port();
        test_done();
    end
endmodule : floppy_port_pin_control_tb_top
`default_nettype wire
